// file: core/pin_irq_pkg.sv
// Purpose: Shared constants and carrier types of the pin interrupt block
// Assumes: Register map is the special function register space of the core
// Notes:   Bit positions are plain indices into the 8-bit registers
package pin_irq_pkg;

  // Register addresses
  localparam logic [7:0] POWER_ADDR = 8'h87;
  localparam logic [7:0] CTRL_ADDR  = 8'h88;
  localparam logic [7:0] XFLG_ADDR  = 8'h95;
  localparam logic [7:0] WAKE_ADDR  = 8'h96;
  localparam logic [7:0] IE_ADDR    = 8'hA8;
  localparam logic [7:0] INTE1_ADDR = 8'hA9;

  // Reset value and writable bits
  localparam logic [7:0] REG_RST     = 8'h00;
  localparam logic [7:0] POWER_MASK  = 8'h8F;
  localparam logic [7:0] IE_MASK     = 8'hBF;
  localparam logic [4:0] XFLG_PAD    = 5'h00;

  // Field positions
  localparam int POWER_IDLE  = 0;
  localparam int POWER_STOP  = 1;
  localparam int CTRL_A_TYPE = 0;
  localparam int CTRL_A_FLAG = 1;
  localparam int CTRL_B_TYPE = 2;
  localparam int CTRL_B_FLAG = 3;
  localparam int XF_TF3    = 0;
  localparam int XF_P1     = 1;
  localparam int XF_C      = 2;
  localparam int IE_A_EN     = 0;
  localparam int IE_B_EN     = 2;
  localparam int IE_GLOBAL   = 7;
  localparam int INTE1_P1_EN = 1;
  localparam int INTE1_C_EN  = 2;

  // Interrupt vectors
  localparam logic [15:0] VEC_A    = 16'h0003;
  localparam logic [15:0] VEC_B    = 16'h0013;
  localparam logic [15:0] VEC_P1   = 16'h0043;
  localparam logic [15:0] VEC_C    = 16'h004B;
  localparam logic [15:0] VEC_NONE = 16'h0000;

  // Stop wake-up warm-up before pins are sampled again
  localparam int WARM_CYCLES_DEF = 16;

  typedef enum logic [1:0] {
    SRC_A  = 2'b00,
    SRC_B  = 2'b01,
    SRC_P1 = 2'b10,
    SRC_C  = 2'b11
  } src_t;

  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_STOP = 2'b10,
    MODE_WARM = 2'b11
  } mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  typedef struct packed {
    logic       ext_a;
    logic       ext_b;
    logic       ext_c;
    logic [7:0] port_one;
  } pins_t;

  typedef struct packed {
    logic ack;
    src_t ack_src;
    logic instr_done;
    logic other_wake;
    logic tf3_set;
  } cpu_in_t;

endpackage

// file: core/pin_sync.sv
// Purpose: Three-stage pin synchroniser with two-sample agreement
// Assumes: Pins idle high, so every stage resets to one
// Notes:   Output level moves only when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 11
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Raw pins and filtered level
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;

  sync_t s_reg;
  sync_t s_next;

  // Stage one is read only by stage two; a glitch on one sample is ignored
  always_comb begin
    s_next     = s_reg;
    s_next.s1  = pin_raw;
    s_next.s2  = s_reg.s1;
    s_next.s3  = s_reg.s2;
    s_next.lvl = (~(s_reg.s2 ^ s_reg.s3) & s_reg.s3) |
                 ((s_reg.s2 ^ s_reg.s3) & s_reg.lvl);
  end

  // State register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin_level = s_reg.lvl;

endmodule
`default_nettype wire

// file: core/pin_interrupt_wakeup.sv
// Purpose: External pin interrupts, Port1 change interrupt, Idle/Stop wake
// Assumes: The core handles priority, vectoring and return from service
// Notes:   Stop wake-up is modelled on a running clock with a warm-up count
//
// How it works
// - Pins A and B are low-level when trigger type is 0, falling-edge when 1
// - Falling edge on pin A or B sets its flag regardless of enable
// - A flag clears when the core acknowledges entry into its service, except A or B in level mode
// - Pin C is falling-edge only; each edge sets its flag regardless of enable
// - Port1 change flag sets on change of a wake-enabled pin only
// - Writing 0 clears an extra flag bit, writing 1 leaves it
// - Idle ends only on an interrupt enabled individually and globally
// - Idle wake enters service at once, resuming after the idle write
// - Power control bit 1 enters Stop, bit 0 enters Idle
// - Stop wake armed per pin enable and per Port1 wake enable bit
// - After Stop wake one instruction runs before any service
// - Entry after Stop needs global enable and a pin low long enough
// - Port1 change raises its flag in Stop without clock sampling
// - Pins come from P3.2, P3.3, P2.7; all four sources wake Stop
// - An enabled pin wakes Stop regardless of the global enable
// - Port1 change interrupt enable does not affect Port1 Stop wake
// - Vectors are 0003, 0013, 0043 and 004B for A, B, Port1, C
`timescale 1ns/10ps
`default_nettype none
module pin_interrupt_wakeup #(
  parameter int WARM_CYCLES = pin_irq_pkg::WARM_CYCLES_DEF,
  parameter int CW          = 8
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // Register access from the core
  input  wire pin_irq_pkg::sfr_req_t sfr,
  output logic [7:0]                 sfr_rdata,
  // Interrupt pins
  input  wire pin_irq_pkg::pins_t    pins,
  // Core handshakes
  input  wire pin_irq_pkg::cpu_in_t  cpu,
  output logic [3:0]                 irq_request,
  output logic [15:0]                irq_vector,
  // Power state
  output logic                       idle_mode,
  output logic                       stop_mode,
  output logic                       idle_wake,
  output logic                       stop_wake,
  output logic                       isr_hold
);
  import pin_irq_pkg::*;

  localparam logic [CW-1:0] WARM_LAST = CW'(WARM_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ONE   = CW'(1);

  typedef struct packed {
    logic [7:0]    power;
    logic [7:0]    timer_and_ext_irq_control;
    logic [2:0]    xflg;
    logic [7:0]    wake_en;
    logic [7:0]    ie;
    logic [2:0]    inte1;
    logic [7:0]    rdata;
    mode_t         mode;
    logic [CW-1:0] warm;
    logic          hold;
    logic          idle_wake;
    logic          stop_wake;
    logic [3:0]    req;
    logic [15:0]   vector;
    logic          prev_a;
    logic          prev_b;
    logic          prev_c;
    logic [7:0]    prev_p1;
  } state_t;

  state_t s_reg;
  state_t s_next;
  pins_t  lvl;

  pin_sync #(
    .W ($bits(pins_t))
  ) u_sync (
    .clock     (clock),
    .rst_b     (rst_b),
    .pin_raw   (pins),
    .pin_level (lvl)
  );

  logic       fall_a;
  logic       fall_b;
  logic       fall_c;
  logic [7:0] p1_chg;
  logic       glob_en;
  logic       a_en;
  logic       b_en;
  logic       c_en;
  logic       p1_en;
  logic       sampling;
  logic [3:0] req_raw;
  logic       stop_any;

  // Edge detection on the filtered levels
  always_comb begin
    fall_a   = s_reg.prev_a & ~lvl.ext_a;
    fall_b   = s_reg.prev_b & ~lvl.ext_b;
    fall_c   = s_reg.prev_c & ~lvl.ext_c;
    p1_chg   = (s_reg.prev_p1 ^ lvl.port_one) & s_reg.wake_en;
    glob_en  = s_reg.ie[IE_GLOBAL];
    a_en     = s_reg.ie[IE_A_EN];
    b_en     = s_reg.ie[IE_B_EN];
    c_en     = s_reg.inte1[INTE1_C_EN];
    p1_en    = s_reg.inte1[INTE1_P1_EN];
    // The clock is treated as stopped for pin sampling in Stop and warm-up
    sampling = (s_reg.mode == MODE_RUN) || (s_reg.mode == MODE_IDLE);
    // individual and global enables both needed
    req_raw  = {s_reg.xflg[XF_C] & c_en & glob_en,
                s_reg.xflg[XF_P1] & p1_en & glob_en,
                s_reg.timer_and_ext_irq_control[CTRL_B_FLAG] & b_en & glob_en,
                s_reg.timer_and_ext_irq_control[CTRL_A_FLAG] & a_en & glob_en};
    // Stop wake armed per source; no global or P1 enable
    stop_any = (a_en & ~lvl.ext_a) | (b_en & ~lvl.ext_b) |
               (c_en & ~lvl.ext_c) | (|p1_chg);
  end

  // Next state: software first, then acknowledge, then hardware sets
  always_comb begin
    s_next           = s_reg;
    s_next.prev_a    = lvl.ext_a;
    s_next.prev_b    = lvl.ext_b;
    s_next.prev_c    = lvl.ext_c;
    s_next.prev_p1   = lvl.port_one;
    s_next.idle_wake = 1'b0;
    s_next.stop_wake = 1'b0;

    if (sfr.wr) begin
      unique case (sfr.addr)
        // power control holds the mode requests
        POWER_ADDR: s_next.power = sfr.wdata & POWER_MASK;
        CTRL_ADDR:  s_next.timer_and_ext_irq_control = sfr.wdata;
        XFLG_ADDR:  s_next.xflg = s_reg.xflg & sfr.wdata[2:0];
        WAKE_ADDR:  s_next.wake_en = sfr.wdata;
        IE_ADDR:    s_next.ie = sfr.wdata & IE_MASK;
        INTE1_ADDR: s_next.inte1 = sfr.wdata[2:0];
        default:    s_next.power = s_next.power;
      endcase
    end

    if (cpu.ack) begin
      unique case (cpu.ack_src)
        SRC_A:  s_next.timer_and_ext_irq_control[CTRL_A_FLAG] = 1'b0;
        SRC_B:  s_next.timer_and_ext_irq_control[CTRL_B_FLAG] = 1'b0;
        SRC_P1: s_next.xflg[XF_P1] = 1'b0;
        SRC_C:  s_next.xflg[XF_C] = 1'b0;
      endcase
    end

    if (sampling) begin
      // level mode follows the pin, edge mode latches
      if (!s_reg.timer_and_ext_irq_control[CTRL_A_TYPE]) begin
        s_next.timer_and_ext_irq_control[CTRL_A_FLAG] = ~lvl.ext_a;
      end else if (fall_a) begin
        s_next.timer_and_ext_irq_control[CTRL_A_FLAG] = 1'b1;
      end
      if (!s_reg.timer_and_ext_irq_control[CTRL_B_TYPE]) begin
        s_next.timer_and_ext_irq_control[CTRL_B_FLAG] = ~lvl.ext_b;
      end else if (fall_b) begin
        s_next.timer_and_ext_irq_control[CTRL_B_FLAG] = 1'b1;
      end
      if (fall_c) begin
        s_next.xflg[XF_C] = 1'b1;
      end
    end

    // Port1 change needs no clock sample, so it sets in every mode
    if (|p1_chg) begin
      s_next.xflg[XF_P1] = 1'b1;
    end
    if (cpu.tf3_set) begin
      s_next.xflg[XF_TF3] = 1'b1;
    end

    // A pending Stop request outranks a pending Idle request
    unique case (s_reg.mode)
      MODE_RUN: begin
        if (s_reg.power[POWER_STOP]) begin
          s_next.mode = MODE_STOP;
        end else if (s_reg.power[POWER_IDLE]) begin
          s_next.mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if ((|req_raw) || (glob_en && cpu.other_wake)) begin
          s_next.mode              = MODE_RUN;
          s_next.power[POWER_IDLE] = 1'b0;
          s_next.idle_wake         = 1'b1;
        end
      end
      MODE_STOP: begin
        if (stop_any) begin
          s_next.mode = MODE_WARM;
          s_next.warm = '0;
        end
      end
      MODE_WARM: begin
        s_next.warm = s_reg.warm + CNT_ONE;
        if (s_reg.warm == WARM_LAST) begin
          s_next.mode             = MODE_RUN;
          s_next.power[POWER_STOP] = 1'b0;
          s_next.stop_wake        = 1'b1;
          // hold service until one instruction has run
          s_next.hold             = 1'b1;
          // a pin still low after warm-up is sampled as a trigger
          if (!lvl.ext_a) begin
            s_next.timer_and_ext_irq_control[CTRL_A_FLAG] = 1'b1;
          end
          if (!lvl.ext_b) begin
            s_next.timer_and_ext_irq_control[CTRL_B_FLAG] = 1'b1;
          end
          if (!lvl.ext_c) begin
            s_next.xflg[XF_C] = 1'b1;
          end
        end
      end
    endcase

    // first instruction after Stop releases the hold
    if (s_reg.hold && cpu.instr_done) begin
      s_next.hold = 1'b0;
    end

    // requests reach the core at once, also from Idle
    if (s_reg.hold || (s_reg.mode == MODE_STOP) ||
        (s_reg.mode == MODE_WARM)) begin
      s_next.req = 4'h0;
    end else begin
      s_next.req = req_raw;
    end

    // vector of the lowest-address pending source
    if (s_next.req[SRC_A]) begin
      s_next.vector = VEC_A;
    end else if (s_next.req[SRC_B]) begin
      s_next.vector = VEC_B;
    end else if (s_next.req[SRC_P1]) begin
      s_next.vector = VEC_P1;
    end else if (s_next.req[SRC_C]) begin
      s_next.vector = VEC_C;
    end else begin
      s_next.vector = VEC_NONE;
    end

    // Read data is captured on the strobe; unmapped addresses read zero
    if (sfr.rd) begin
      unique case (sfr.addr)
        POWER_ADDR: s_next.rdata = s_reg.power;
        CTRL_ADDR:  s_next.rdata = s_reg.timer_and_ext_irq_control;
        XFLG_ADDR:  s_next.rdata = {XFLG_PAD, s_reg.xflg};
        WAKE_ADDR:  s_next.rdata = s_reg.wake_en;
        IE_ADDR:    s_next.rdata = s_reg.ie;
        INTE1_ADDR: s_next.rdata = {XFLG_PAD, s_reg.inte1};
        default:    s_next.rdata = REG_RST;
      endcase
    end
  end

  // State register; previous levels reset high to match idle pins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_reg         <= '0;
      s_reg.prev_a  <= 1'b1;
      s_reg.prev_b  <= 1'b1;
      s_reg.prev_c  <= 1'b1;
      s_reg.prev_p1 <= 8'hFF;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata   = s_reg.rdata;
  assign irq_request = s_reg.req;
  assign irq_vector  = s_reg.vector;
  assign idle_mode   = (s_reg.mode == MODE_IDLE);
  assign stop_mode   = (s_reg.mode == MODE_STOP) || (s_reg.mode == MODE_WARM);
  assign idle_wake   = s_reg.idle_wake;
  assign stop_wake   = s_reg.stop_wake;
  assign isr_hold    = s_reg.hold;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence warm_done;
    (s_reg.mode == MODE_WARM) ##1 (s_reg.mode == MODE_RUN);
  endsequence

  sequence edge_a_run;
    sampling && s_reg.timer_and_ext_irq_control[CTRL_A_TYPE] && fall_a;
  endsequence

  a_level_follows: assert property (
    (sampling && !s_reg.timer_and_ext_irq_control[CTRL_A_TYPE]) |=>
      (s_reg.timer_and_ext_irq_control[CTRL_A_FLAG] == !$past(lvl.ext_a)))
    else $error("level mode flag does not follow pin A");

  a_edge_sets_a: assert property (
    edge_a_run |=> s_reg.timer_and_ext_irq_control[CTRL_A_FLAG])
    else $error("falling edge on pin A did not set its flag");

  a_edge_sets_c: assert property (
    (sampling && fall_c) |=> s_reg.xflg[XF_C])
    else $error("falling edge on pin C did not set its flag");

  a_p1_change_set: assert property (
    (|p1_chg) |=> s_reg.xflg[XF_P1])
    else $error("enabled Port1 change did not set its flag");

  a_ack_clears_c: assert property (
    (cpu.ack && cpu.ack_src == SRC_C && !(sampling && fall_c) &&
     !(s_reg.mode == MODE_WARM)) |=> !s_reg.xflg[XF_C])
    else $error("acknowledge did not clear pin C flag");

  a_write_zero: assert property (
    (sfr.wr && sfr.addr == XFLG_ADDR && !sfr.wdata[XF_C] &&
     !fall_c && s_reg.mode == MODE_RUN) |=> !s_reg.xflg[XF_C])
    else $error("writing zero did not clear pin C flag");

  a_idle_exit: assert property (
    (s_reg.mode == MODE_IDLE && |req_raw) |=>
      (s_reg.mode == MODE_RUN) && s_reg.idle_wake &&
      !s_reg.power[POWER_IDLE])
    else $error("enabled request did not end Idle");

  a_idle_stays: assert property (
    (s_reg.mode == MODE_IDLE && !glob_en) |=> (s_reg.mode == MODE_IDLE))
    else $error("Idle ended without global enable");

  a_stop_no_ea: assert property (
    (s_reg.mode == MODE_STOP && a_en && !lvl.ext_a) |=>
      (s_reg.mode == MODE_WARM) ##[1:300] (s_reg.mode == MODE_RUN))
    else $error("enabled pin A did not wake from Stop");

  a_stop_hold: assert property (
    warm_done |-> s_reg.hold && stop_wake && (irq_request == 4'h0))
    else $error("service not held after Stop wake");

  a_vector_a: assert property (
    irq_request[SRC_A] |-> (irq_vector == 16'h0003))
    else $error("wrong vector for pin A");

  a_stop_entry: assert property (
    (s_reg.mode == MODE_RUN && s_reg.power[POWER_STOP]) |=> stop_mode)
    else $error("stop request did not enter Stop");

endmodule
`default_nettype wire

// file: tb/core_model.sv
// Purpose: Core side partner that takes service entries and retires code
// Assumes: Stimulus moves on the falling edge, the block samples on rising
// Notes:   Timer and serial sources stay quiet, their inputs held at zero
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Block outputs observed
  input  wire logic [3:0]           irq_request,
  input  wire logic [15:0]          irq_vector,
  // Behaviour knobs
  input  wire logic                 ack_en,
  input  wire logic                 done_en,
  input  wire logic                 slow,
  // Core handshakes
  output var  pin_irq_pkg::cpu_in_t cpu
);
  import pin_irq_pkg::*;
  logic [2:0] wait_cnt;

  function automatic src_t src_of(input logic [15:0] v);
    case (v)
      VEC_B:   return SRC_B;
      VEC_P1:  return SRC_P1;
      VEC_C:   return SRC_C;
      default: return SRC_A;
    endcase
  endfunction

  initial cpu = '0;
  initial wait_cnt = 3'h0;

  // service entry pulse
  // A slow core lets a request stand longer before it is taken
  always @(negedge clock) begin
    cpu.ack <= 1'b0;
    cpu.instr_done <= done_en & rst_b;
    if (!rst_b || !ack_en || irq_request == 4'h0) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt == (slow ? 3'h4 : 3'h1)) begin
      cpu.ack <= 1'b1;
      cpu.ack_src <= src_of(irq_vector);
      wait_cnt <= 3'h0;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/pin_interrupt_wakeup_test.sv
// Purpose: Self-checking bench of the pin interrupt and wake-up block
// Assumes: Warm-up shortened to two cycles so Stop runs stay brief
// Notes:   Pins idle high; every wait is bounded
`timescale 1ns/10ps
`default_nettype none
module pin_interrupt_wakeup_test;
  import pin_irq_pkg::*;
  logic                 clock;
  logic                 rst_b;
  sfr_req_t             sfr;
  pins_t                pins;
  cpu_in_t              cpu;
  logic [7:0]           sfr_rdata;
  logic [3:0]           irq_request;
  logic [15:0]          irq_vector;
  logic                 idle_mode;
  logic                 stop_mode;
  logic                 idle_wake;
  logic                 stop_wake;
  logic                 isr_hold;
  logic                 ack_en;
  logic                 done_en;
  logic                 slow;
  int                   mismatches;
  int                   n_checks;
  int                   cycles;

  pin_interrupt_wakeup #(.WARM_CYCLES(2)) i_pin_interrupt_wakeup (
    .clock(clock), .rst_b(rst_b), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .pins(pins), .cpu(cpu), .irq_request(irq_request),
    .irq_vector(irq_vector), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .idle_wake(idle_wake), .stop_wake(stop_wake), .isr_hold(isr_hold));

  core_model i_core_model (
    .clock(clock), .rst_b(rst_b), .irq_request(irq_request),
    .irq_vector(irq_vector), .ack_en(ack_en), .done_en(done_en),
    .slow(slow), .cpu(cpu));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes drop with a spare cycle, so calls may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(negedge clock);
    sfr.wr = 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr.addr = a;
    sfr.rd = 1'b1;
    @(negedge clock);
    sfr.rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, exp});
    @(negedge clock);
  endtask

  task automatic idle_cycles(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic t_reset();
    rd(8'h87, 8'h00);
    rd(8'h88, 8'h00);
    rd(8'h95, 8'h00);
    rd(8'h77, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_edge_a();
    slow = 1'b1;
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h81);
    pins.ext_a = 1'b0;
    for (int k = 0; k < 20 && irq_request[0] !== 1'b1; k++) @(negedge clock);
    chk({12'h000, irq_request}, 16'h0001);
    chk(irq_vector, 16'h0003);
    for (int k = 0; k < 20 && irq_request[0] !== 1'b0; k++) @(negedge clock);
    rd(8'h88, 8'h01);
    pins.ext_a = 1'b1;
    $display("test edge_a done");
  endtask

  task automatic t_flag_b();
    wr(8'h88, 8'h05);
    pins.ext_b = 1'b0;
    idle_cycles(10);
    rd(8'h88, 8'h0D);
    chk({12'h000, irq_request}, 16'h0000);
    pins.ext_b = 1'b1;
    wr(8'h88, 8'h00);
    $display("test flag_b done");
  endtask

  task automatic t_xflags();
    pins.ext_c = 1'b0;
    wr(8'h96, 8'h01);
    pins.port_one[1] = 1'b0;
    idle_cycles(10);
    rd(8'h95, 8'h04);
    pins.port_one[0] = 1'b0;
    idle_cycles(10);
    rd(8'h95, 8'h06);
    wr(8'h95, 8'hFD);
    rd(8'h95, 8'h04);
    wr(8'h95, 8'hFB);
    rd(8'h95, 8'h00);
    pins.ext_c = 1'b1;
    pins.port_one = 8'hFF;
    idle_cycles(10);
    wr(8'h95, 8'h00);
    $display("test xflags done");
  endtask

  task automatic t_level_a();
    slow = 1'b0;
    pins.ext_a = 1'b0;
    for (int k = 0; k < 20 && irq_request[0] !== 1'b1; k++) @(negedge clock);
    idle_cycles(20);
    chk({12'h000, irq_request}, 16'h0001);
    pins.ext_a = 1'b1;
    idle_cycles(10);
    chk({12'h000, irq_request}, 16'h0000);
    $display("test level_a done");
  endtask

  task automatic t_idle();
    wr(8'h88, 8'h01);
    wr(8'hA8, 8'h01);
    wr(8'h87, 8'h01);
    idle_cycles(2);
    chk({15'h0000, idle_mode}, 16'h0001);
    pins.ext_a = 1'b0;
    idle_cycles(12);
    chk({15'h0000, idle_mode}, 16'h0001);
    pins.ext_a = 1'b1;
    wr(8'hA8, 8'h81);
    for (int k = 0; k < 10 && idle_mode !== 1'b0; k++) @(negedge clock);
    chk({15'h0000, idle_mode}, 16'h0000);
    for (int k = 0; k < 4 && irq_request[0] !== 1'b1; k++) @(negedge clock);
    chk({12'h000, irq_request}, 16'h0001);
    rd(8'h87, 8'h00);
    $display("test idle done");
  endtask

  task automatic t_stop_a();
    done_en = 1'b0;
    wr(8'h88, 8'h00);
    wr(8'hA8, 8'h01);
    wr(8'h87, 8'h02);
    idle_cycles(2);
    chk({15'h0000, stop_mode}, 16'h0001);
    pins.ext_a = 1'b0;
    for (int k = 0; k < 20 && stop_wake !== 1'b1; k++) @(negedge clock);
    chk({15'h0000, stop_wake}, 16'h0001);
    idle_cycles(5);
    chk({15'h0000, isr_hold}, 16'h0001);
    done_en = 1'b1;
    idle_cycles(3);
    chk({15'h0000, isr_hold}, 16'h0000);
    chk({12'h000, irq_request}, 16'h0000);
    pins.ext_a = 1'b1;
    // Let pin A settle high before Stop is entered again
    idle_cycles(8);
    $display("test stop_a done");
  endtask

  task automatic t_stop_p1();
    wr(8'hA9, 8'h00);
    wr(8'h87, 8'h02);
    idle_cycles(2);
    pins.port_one[0] = 1'b0;
    for (int k = 0; k < 20 && stop_wake !== 1'b1; k++) @(negedge clock);
    chk({15'h0000, stop_wake}, 16'h0001);
    rd(8'h95, 8'h02);
    pins.port_one[0] = 1'b1;
    $display("test stop_p1 done");
  endtask

  initial begin
    rst_b = 1'b0;
    sfr = '0;
    pins = '1;
    ack_en = 1'b1;
    done_en = 1'b1;
    slow = 1'b0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    idle_cycles(6);
    t_reset();
    t_edge_a();
    t_flag_b();
    t_xflags();
    t_level_a();
    t_idle();
    t_stop_a();
    t_stop_p1();
    summarize();
  end
endmodule
`default_nettype wire
